//--- src/dsr_defs.svh
// Widths, timing counts and limits for the DDR separate-I/O burst SRAM port
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

`define DSR_ADDR_W        20
`define DSR_WORD_W        18
`define DSR_LINE_W        36
`define DSR_LANE_W        9
`define DSR_LANES         4
`define DSR_BWS_W         2

`define DSR_SYS_MHZ       10
`define DSR_ZQ_PERIOD     1024
`define DSR_ZQ_CNT_W      10
`define DSR_LOCK_TIME_US  20
`define DSR_LOCK_CYCLES   (`DSR_LOCK_TIME_US * `DSR_SYS_MHZ)
`define DSR_PLL_STOP_NS   30
`define DSR_STOP_CYCLES   ((`DSR_PLL_STOP_NS * `DSR_SYS_MHZ + 999) / 1000)
`define DSR_HS_SLACK      6
`define DSR_STALL_LIMIT   (`DSR_STOP_CYCLES + `DSR_HS_SLACK)
`define DSR_TMR_W         8

`endif

//--- src/dsr_pkg.sv
// Types and the lane merge helper for the DDR separate-I/O burst SRAM port
`include "dsr_defs.svh"
package dsr_pkg;
    typedef logic [`DSR_ADDR_W-1:0] dsr_addr_t;
    typedef logic [`DSR_WORD_W-1:0] dsr_word_t;
    typedef logic [`DSR_LINE_W-1:0] dsr_line_t;
    typedef logic [`DSR_LANES-1:0]  dsr_be_t;
    typedef logic [`DSR_BWS_W-1:0]  dsr_bws_t;
    typedef enum logic [1:0] {DSR_CMD_NOP, DSR_CMD_RD, DSR_CMD_WR} dsr_cmd_t;

    // Overlays the enabled 9-bit lanes of data onto base
    function automatic dsr_line_t dsr_lane_merge(input dsr_line_t base,
                                                 input dsr_line_t data,
                                                 input dsr_be_t   be);
        dsr_line_t res;
        res = base;
        for (int i = 0; i < `DSR_LANES; i++) begin
            if (be[i]) begin
                res[i*`DSR_LANE_W +: `DSR_LANE_W] = data[i*`DSR_LANE_W +: `DSR_LANE_W];
            end
        end
        return res;
    endfunction
endpackage

//--- src/dsr_mem.sv
// Line array with lane-masked write and registered read-first output
`timescale 1ns/10ps
`include "dsr_defs.svh"
module dsr_mem (
    // Clock
    input  wire logic              i_clk,
    // Write port
    input  wire logic              i_we,
    input  wire dsr_pkg::dsr_addr_t i_waddr,
    input  wire dsr_pkg::dsr_line_t i_wdata,
    input  wire dsr_pkg::dsr_be_t   i_wbe,
    // Read port
    input  wire logic              i_re,
    input  wire dsr_pkg::dsr_addr_t i_raddr,
    output dsr_pkg::dsr_line_t      o_rdata
);
    import dsr_pkg::*;

    dsr_line_t mem_r [0:(1 << `DSR_ADDR_W)-1];

    // A read and a write at one edge return the old contents
    always_ff @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= mem_r[i_raddr];
        end
        for (int i = 0; i < `DSR_LANES; i++) begin
            if (i_we && i_wbe[i]) begin
                mem_r[i_waddr][i*`DSR_LANE_W +: `DSR_LANE_W] <=
                    i_wdata[i*`DSR_LANE_W +: `DSR_LANE_W];
            end
        end
    end
endmodule

//--- src/dsr_port.sv
// DDR separate-I/O two-word burst SRAM port: commands, data paths, clocks, housekeeping
// Behaviour
// - Read latency 1.5 cycles with PLL enabled
// - Read latency 1 cycle with PLL disabled
// - Commands start only on input clock rise
// - Read data launched by output clock pair
// - Read: select high, strobe low, latch address
// - Two 18-bit read words, lower first
// - New read accepted every clock
// - Finish reads, then tristate outputs
// - Write: select low, strobe low, latch address
// - Write words on next rise and fall
// - New write accepted every clock
// - Idle after pending writes, ignore inputs
// - Byte selects sampled per data word
// - Select 0 bits 8:0, select 1 bits 17:9
// - Both output clocks high selects single clock
// - Write held in registers until next write
// - Impedance update every 1024 cycles
// - Free-running echo clocks from output clocks
// - Deselected with outputs tristated after reset
`timescale 1ns/10ps
`include "dsr_defs.svh"
module dsr_port (
    // System clock domain
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    // Link clocks
    input  wire logic               i_k_clk,
    input  wire logic               i_c_clk,
    input  wire logic               i_c_clk_n,
    input  wire logic               i_pll_disable_n,
    // Command and address
    input  wire logic               i_load_strobe_n,
    input  wire logic               i_rw,
    input  wire dsr_pkg::dsr_addr_t i_addr,
    // Write data
    input  wire dsr_pkg::dsr_word_t i_d,
    input  wire dsr_pkg::dsr_bws_t  i_byte_write_sel_n,
    // Read data and echo clocks
    output dsr_pkg::dsr_word_t      o_q,
    output logic                    o_q_oe,
    output logic                    o_echo_timing,
    output logic                    o_echo_timing_n,
    // Housekeeping
    output logic                    o_zq_update,
    output logic                    o_pll_locked
);
    import dsr_pkg::*;

    localparam logic [`DSR_ZQ_CNT_W-1:0] ZQ_LAST = `DSR_ZQ_CNT_W'(`DSR_ZQ_PERIOD - 1);
    localparam logic [`DSR_TMR_W-1:0]    LOCK_CNT = `DSR_TMR_W'(`DSR_LOCK_CYCLES);
    localparam logic [`DSR_TMR_W-1:0]    STALL_CNT = `DSR_TMR_W'(`DSR_STALL_LIMIT);

    // Link-domain reset and pin synchronisers
    logic       rst_k_meta_r;
    logic       rst_k_r;
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic       single_clk_r;
    logic       ddr2_mode;
    logic       out_clk;

    always_ff @(posedge i_k_clk) begin
        rst_k_meta_r <= i_rst;
        rst_k_r      <= rst_k_meta_r;
        pin_meta_r   <= {i_pll_disable_n, i_c_clk, i_c_clk_n};
        pin_sync_r   <= pin_meta_r;
    end

    // Strap is followed while reset is held and frozen at release
    always_ff @(posedge i_k_clk) begin
        if (rst_k_r) begin
            single_clk_r <= pin_sync_r[1] & pin_sync_r[0];
        end
    end

    assign ddr2_mode       = pin_sync_r[2];
    // C is the same frequency as K with bounded skew, so it shares the K domain
    assign out_clk         = single_clk_r ? i_k_clk : i_c_clk;
    assign o_echo_timing   = out_clk;
    assign o_echo_timing_n = ~out_clk;

    // Command decode
    dsr_cmd_t cmd;
    logic     cmd_rd;
    logic     cmd_wr;
    assign cmd    = i_load_strobe_n ? DSR_CMD_NOP : (i_rw ? DSR_CMD_RD : DSR_CMD_WR);
    assign cmd_rd = (cmd == DSR_CMD_RD);
    assign cmd_wr = (cmd == DSR_CMD_WR);

    // Pipeline and write staging
    logic      rd_v1_r;
    logic      rd_v2_r;
    logic      wr_v1_r;
    logic      wr_v2_r;
    dsr_addr_t wr_addr1_r;
    dsr_addr_t wr_addr2_r;
    dsr_word_t d0_r;
    dsr_word_t d1_r;
    dsr_bws_t  be0_r;
    dsr_bws_t  be1_r;
    logic      posted_v_r;
    dsr_addr_t posted_addr_r;
    dsr_line_t posted_data_r;
    dsr_be_t   posted_be_r;
    dsr_line_t fw_p_data_r;
    dsr_be_t   fw_p_be_r;
    dsr_line_t fw_s_data_r;
    dsr_be_t   fw_s_be_r;
    dsr_line_t rd_word_r;
    dsr_line_t mem_rdata;
    dsr_line_t stg_data;
    dsr_be_t   stg_be;
    dsr_line_t rd_merged;
    logic      s_hit;
    logic      p_hit;
    logic      mem_we;

    assign stg_data  = {d1_r, d0_r};
    assign stg_be    = {be1_r, be0_r};
    assign s_hit     = wr_v2_r && (wr_addr2_r == i_addr);
    assign p_hit     = posted_v_r && (posted_addr_r == i_addr);
    // Staged write is newer than the posted one, so it is laid on last
    assign rd_merged = dsr_lane_merge(dsr_lane_merge(mem_rdata, fw_p_data_r, fw_p_be_r),
                                      fw_s_data_r, fw_s_be_r);
    // Posted line reaches the array only when the next write takes its place
    assign mem_we    = wr_v2_r && posted_v_r;

    always_ff @(posedge i_k_clk) begin
        if (rst_k_r) begin
            rd_v1_r    <= 1'b0;
            rd_v2_r    <= 1'b0;
            wr_v1_r    <= 1'b0;
            wr_v2_r    <= 1'b0;
            posted_v_r <= 1'b0;
        end else begin
            rd_v1_r    <= cmd_rd;
            rd_v2_r    <= rd_v1_r;
            wr_v1_r    <= cmd_wr;
            wr_v2_r    <= wr_v1_r;
            posted_v_r <= posted_v_r | wr_v2_r;
        end
    end

    always_ff @(posedge i_k_clk) begin
        if (cmd_wr) begin
            wr_addr1_r <= i_addr;
        end
        if (wr_v1_r) begin
            wr_addr2_r <= wr_addr1_r;
            d0_r       <= i_d;
            be0_r      <= ~i_byte_write_sel_n;
        end
        if (wr_v2_r) begin
            posted_addr_r <= wr_addr2_r;
            posted_data_r <= stg_data;
            posted_be_r   <= stg_be;
        end
        if (cmd_rd) begin
            fw_s_data_r <= stg_data;
            fw_s_be_r   <= s_hit ? stg_be : '0;
            fw_p_data_r <= posted_data_r;
            fw_p_be_r   <= p_hit ? posted_be_r : '0;
        end
        rd_word_r <= rd_merged;
    end

    // Second write word on the falling edge of K, the rise of its complement
    always_ff @(negedge i_k_clk) begin
        if (wr_v2_r) begin
            d1_r  <= i_d;
            be1_r <= ~i_byte_write_sel_n;
        end
    end

    dsr_mem u_mem (
        .i_clk   (i_k_clk),
        .i_we    (mem_we),
        .i_waddr (posted_addr_r),
        .i_wdata (posted_data_r),
        .i_wbe   (posted_be_r),
        .i_re    (cmd_rd),
        .i_raddr (i_addr),
        .o_rdata (mem_rdata)
    );

    // Output registers, one per edge of the output clock
    dsr_word_t q_pos_r;
    dsr_word_t q_neg_r;
    logic      oe_pos_r;
    logic      oe_neg_r;
    dsr_word_t rd_lo;
    dsr_word_t rd_hi;
    dsr_word_t mrg_lo;

    assign rd_lo  = rd_word_r[`DSR_WORD_W-1:0];
    assign rd_hi  = rd_word_r[`DSR_LINE_W-1:`DSR_WORD_W];
    assign mrg_lo = rd_merged[`DSR_WORD_W-1:0];
    assign o_q    = out_clk ? q_pos_r : q_neg_r;
    assign o_q_oe = out_clk ? oe_pos_r : oe_neg_r;

    // Copies taken on the K fall feed the rise registers, so a C rise that lags
    // K by less than half a period never sees the K-rise pipeline update
    logic      rd_v1_h_r;
    logic      rd_v2_h_r;
    dsr_word_t lo_h_r;
    dsr_word_t hi_h_r;

    always_ff @(negedge i_k_clk) begin
        rd_v1_h_r <= rd_v1_r;
        rd_v2_h_r <= rd_v2_r;
        lo_h_r    <= mrg_lo;
        hi_h_r    <= rd_hi;
    end

    always_ff @(posedge out_clk) begin
        if (rst_k_r) begin
            oe_pos_r <= 1'b0;
            q_pos_r  <= '0;
        end else if (ddr2_mode) begin
            oe_pos_r <= rd_v2_h_r;
            if (rd_v2_h_r) begin
                q_pos_r <= hi_h_r;
            end
        end else begin
            oe_pos_r <= rd_v1_h_r;
            if (rd_v1_h_r) begin
                q_pos_r <= lo_h_r;
            end
        end
    end

    always_ff @(negedge out_clk) begin
        if (rst_k_r) begin
            oe_neg_r <= 1'b0;
            q_neg_r  <= '0;
        end else begin
            oe_neg_r <= rd_v2_r;
            if (rd_v2_r) begin
                q_neg_r <= ddr2_mode ? rd_lo : rd_hi;
            end
        end
    end

    // Clock-alive handshake into the system domain
    logic hs_req_r;
    logic hs_k_meta_r;
    logic hs_k_sync_r;
    logic hs_ack_r;

    always_ff @(posedge i_k_clk) begin
        hs_k_meta_r <= hs_req_r;
        hs_k_sync_r <= hs_k_meta_r;
        if (rst_k_r) begin
            hs_ack_r <= 1'b0;
        end else begin
            hs_ack_r <= hs_k_sync_r;
        end
    end

    logic                    ack_meta_r;
    logic                    ack_sync_r;
    logic                    pll_meta_r;
    logic                    pll_sync_r;
    logic                    alive;
    logic                    stopped;
    logic [`DSR_TMR_W-1:0]   idle_cnt_r;
    logic [`DSR_TMR_W-1:0]   lock_cnt_r;
    logic [`DSR_ZQ_CNT_W-1:0] zq_cnt_r;

    assign alive   = (ack_sync_r == hs_req_r);
    assign stopped = (idle_cnt_r >= STALL_CNT);

    always_ff @(posedge i_clk_sys) begin
        ack_meta_r <= hs_ack_r;
        ack_sync_r <= ack_meta_r;
        pll_meta_r <= i_pll_disable_n;
        pll_sync_r <= pll_meta_r;
    end

    // A stalled K clock restarts the lock timer, as a relock would
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hs_req_r     <= 1'b0;
            idle_cnt_r   <= '0;
            lock_cnt_r   <= '0;
            o_pll_locked <= 1'b0;
        end else begin
            hs_req_r <= alive ? ~hs_req_r : hs_req_r;
            if (alive) begin
                idle_cnt_r <= '0;
            end else if (!stopped) begin
                idle_cnt_r <= idle_cnt_r + 1'b1;
            end
            if (stopped || !pll_sync_r) begin
                lock_cnt_r <= '0;
            end else if (lock_cnt_r != LOCK_CNT) begin
                lock_cnt_r <= lock_cnt_r + 1'b1;
            end
            o_pll_locked <= pll_sync_r && (lock_cnt_r == LOCK_CNT);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            zq_cnt_r    <= '0;
            o_zq_update <= 1'b0;
        end else begin
            zq_cnt_r    <= zq_cnt_r + 1'b1;
            o_zq_update <= (zq_cnt_r == ZQ_LAST);
        end
    end

    // Checks
    logic [`DSR_ZQ_CNT_W:0] zq_gap_r;
    logic                   zq_seen_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            zq_gap_r  <= '0;
            zq_seen_r <= 1'b0;
        end else begin
            zq_gap_r  <= o_zq_update ? '0 : zq_gap_r + 1'b1;
            zq_seen_r <= zq_seen_r | o_zq_update;
        end
    end

    property p_ddr2_latency;
        @(posedge i_k_clk) disable iff (rst_k_r)
        (cmd_rd && ddr2_mode) |-> ##3 (oe_pos_r && q_pos_r == $past(rd_hi));
    endproperty
    a_ddr2_latency: assert property (p_ddr2_latency) else $error("DDR II read word late");

    property p_ddr1_latency;
        @(posedge i_k_clk) disable iff (rst_k_r)
        (cmd_rd && !ddr2_mode) |-> ##2 (oe_pos_r && q_pos_r == $past(mrg_lo));
    endproperty
    a_ddr1_latency: assert property (p_ddr1_latency) else $error("DDR I read word late");

    property p_rd_pipe;
        @(posedge i_k_clk) disable iff (rst_k_r)
        cmd_rd |=> rd_v1_r ##1 rd_v2_r;
    endproperty
    a_rd_pipe: assert property (p_rd_pipe) else $error("Read not pipelined");

    property p_wr_capture;
        @(posedge i_k_clk) disable iff (rst_k_r)
        cmd_wr |-> ##2 (wr_v2_r && d0_r == $past(i_d) && wr_addr2_r == $past(i_addr, 2));
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("Write word lost");

    property p_bws_mask;
        @(posedge i_k_clk) disable iff (rst_k_r)
        wr_v1_r |=> (be0_r == ~$past(i_byte_write_sel_n));
    endproperty
    a_bws_mask: assert property (p_bws_mask) else $error("Byte select not sampled");

    property p_posted_load;
        @(posedge i_k_clk) disable iff (rst_k_r)
        wr_v2_r |=> (posted_v_r && posted_addr_r == $past(wr_addr2_r));
    endproperty
    a_posted_load: assert property (p_posted_load) else $error("Posted write not held");

    property p_posted_hold;
        @(posedge i_k_clk) disable iff (rst_k_r)
        (posted_v_r && !wr_v2_r) |=> $stable(posted_data_r) && $stable(posted_addr_r);
    endproperty
    a_posted_hold: assert property (p_posted_hold) else $error("Posted write moved");

    property p_tristate_idle;
        @(posedge i_k_clk) disable iff (rst_k_r)
        (!rd_v1_r && !rd_v2_r)[*2] |-> (!oe_pos_r && !oe_neg_r);
    endproperty
    a_tristate_idle: assert property (p_tristate_idle) else $error("Outputs not released");

    property p_zq_period;
        @(posedge i_clk_sys) disable iff (i_rst)
        (o_zq_update && zq_seen_r) |-> (zq_gap_r == `DSR_ZQ_PERIOD - 1);
    endproperty
    a_zq_period: assert property (p_zq_period) else $error("Impedance update off period");

    c_back_to_back: cover property (@(posedge i_k_clk) disable iff (rst_k_r) cmd_rd ##1 cmd_rd);
    c_forward_hit:  cover property (@(posedge i_k_clk) disable iff (rst_k_r) cmd_rd && s_hit);
    c_posted_hit:   cover property (@(posedge i_k_clk) disable iff (rst_k_r) cmd_rd && p_hit);
    c_pll_locked:   cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_pll_locked));
endmodule

//--- dv/dsr_ctl_model.sv
// Memory controller model: link clocks, commands and write data bursts
`timescale 1ns/10ps
module dsr_ctl_model (
    // Bench control
    input  wire logic          i_strap,
    input  wire logic          i_k_run,
    // Link side
    output logic               o_k_clk,
    output logic               o_c_clk,
    output logic               o_c_clk_n,
    output logic               o_load_strobe_n,
    output logic               o_rw,
    output dsr_pkg::dsr_addr_t o_addr,
    output dsr_pkg::dsr_word_t o_d,
    output dsr_pkg::dsr_bws_t  o_bws_n
);
    import dsr_pkg::*;

    logic      c_raw;
    logic      pend_v;
    dsr_line_t pend_w;
    dsr_bws_t  pend_b0;
    dsr_bws_t  pend_b1;

    // K stands high while stopped; odd start offset keeps it off the system clock edges
    initial begin
        o_k_clk = 1'b1;
        c_raw = 1'b1;
        pend_v = 1'b0;
        o_load_strobe_n = 1'b1;
        o_rw = 1'b0;
        o_addr = '0;
        o_d = '0;
        o_bws_n = 2'h3;
        #1.3;
        forever begin
            #6;
            o_k_clk = i_k_run ? ~o_k_clk : 1'b1;
        end
    end

    // Output clock lags K by a board flight time
    always @(o_k_clk) c_raw <= #2 o_k_clk;
    assign o_c_clk   = i_strap ? 1'b1 : c_raw;
    assign o_c_clk_n = i_strap ? 1'b1 : ~c_raw;

    // One K cycle: command for this rise plus the data of the previous write.
    // Unused address, data and byte-select lines carry the inverse of their last value, never a stale copy.
    task automatic cycle(input logic ld, input logic rd, input dsr_addr_t a,
                         input dsr_line_t w, input dsr_bws_t b0, input dsr_bws_t b1);
        @(negedge o_k_clk);
        // The K fall samples the second write word, so nothing moves on it
        #1;
        o_load_strobe_n = ~ld;
        o_rw = rd;
        o_addr = ld ? a : ~o_addr;
        o_d = pend_v ? pend_w[17:0] : ~o_d;
        o_bws_n = pend_v ? pend_b0 : ~o_bws_n;
        @(posedge o_k_clk);
        #3;
        o_d = pend_v ? pend_w[35:18] : ~o_d;
        o_bws_n = pend_v ? pend_b1 : ~o_bws_n;
        pend_v = ld & ~rd;
        pend_w = w;
        pend_b0 = b0;
        pend_b1 = b1;
    endtask
endmodule

//--- dv/dsr_port_tb_top.sv
// Self-checking bench for the DDR separate-I/O burst SRAM port
`timescale 1ns/10ps
module dsr_port_tb_top;
    import dsr_pkg::*;

    logic      clk_sys;
    logic      rst;
    logic      pll_en;
    logic      strap;
    logic      k_run;
    logic      k_clk;
    logic      c_clk;
    logic      c_clk_n;
    logic      ld_n;
    logic      rw;
    dsr_addr_t addr;
    dsr_word_t d;
    dsr_bws_t  bws_n;
    dsr_word_t q;
    logic      q_oe;
    logic      echo;
    logic      echo_n;
    logic      zq;
    logic      locked;
    logic      oclk;
    int        failures;
    int        num_checks;

    assign oclk = strap ? k_clk : c_clk;

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    dsr_ctl_model ctl (.i_strap(strap), .i_k_run(k_run), .o_k_clk(k_clk), .o_c_clk(c_clk),
        .o_c_clk_n(c_clk_n), .o_load_strobe_n(ld_n), .o_rw(rw), .o_addr(addr), .o_d(d),
        .o_bws_n(bws_n));

    dsr_port DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_k_clk(k_clk), .i_c_clk(c_clk),
        .i_c_clk_n(c_clk_n), .i_pll_disable_n(pll_en), .i_load_strobe_n(ld_n), .i_rw(rw),
        .i_addr(addr), .i_d(d), .i_byte_write_sel_n(bws_n), .o_q(q), .o_q_oe(q_oe),
        .o_echo_timing(echo), .o_echo_timing_n(echo_n), .o_zq_update(zq),
        .o_pll_locked(locked));

    task automatic chk_word(input string what, input dsr_word_t exp, input dsr_word_t got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        failures++;
        $display("MISMATCH wait expected event seen none");
        wrap_up();
    endtask

    function automatic dsr_line_t lane_exp(input dsr_line_t base, input dsr_line_t dat,
                                           input dsr_bws_t b0, input dsr_bws_t b1);
        logic [3:0] en;
        en = ~{b1, b0};
        lane_exp = base;
        for (int j = 0; j < 4; j++) begin
            if (en[j]) lane_exp[j*9 +: 9] = dat[j*9 +: 9];
        end
    endfunction

    task automatic idle(input int n);
        repeat (n) ctl.cycle(1'b0, 1'b0, '0, '0, 2'h3, 2'h3);
    endtask

    task automatic wr(input dsr_addr_t a, input dsr_line_t w, input dsr_bws_t b0,
                      input dsr_bws_t b1);
        ctl.cycle(1'b1, 1'b0, a, w, b0, b1);
    endtask

    // Output clock pair times read data: C, or K in single-clock mode
    task automatic expect_rd(input dsr_line_t l0, input dsr_line_t l1, input int n,
                             input logic ddr2);
        dsr_line_t ln;
        @(posedge oclk);
        for (int i = 0; i < n; i++) begin
            ln = (i == 0) ? l0 : l1;
            if (ddr2) @(negedge oclk);
            #3;
            chk_bit("q_oe", 1'b1, q_oe);
            chk_word("q word0", ln[17:0], q);
            if (ddr2) @(posedge oclk);
            else @(negedge oclk);
            #3;
            chk_word("q word1", ln[35:18], q);
            if (!ddr2) @(posedge oclk);
        end
        if (ddr2) @(negedge oclk);
        #3;
        chk_bit("q_oe idle", 1'b0, q_oe);
    endtask

    task automatic rd2(input dsr_addr_t a0, input dsr_addr_t a1, input int n,
                       input dsr_line_t e0, input dsr_line_t e1, input logic ddr2);
        ctl.cycle(1'b1, 1'b1, a0, '0, 2'h3, 2'h3);
        fork
            expect_rd(e0, e1, n, ddr2);
            begin
                if (n > 1) ctl.cycle(1'b1, 1'b1, a1, '0, 2'h3, 2'h3);
                idle(4);
            end
        join
    endtask

    task automatic do_reset(input logic pll, input logic st);
        @(negedge clk_sys);
        rst = 1'b1;
        pll_en = pll;
        strap = st;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Stable K for the lock time before lock is trusted
    task automatic t_lock();
        repeat (148) @(negedge clk_sys);
        chk_bit("locked early", 1'b0, locked);
        repeat (100) @(negedge clk_sys);
        chk_bit("locked", 1'b1, locked);
        k_run = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk_bit("locked stall", 1'b0, locked);
        k_run = 1'b1;
        repeat (260) @(negedge clk_sys);
        chk_bit("relocked", 1'b1, locked);
        $display("done lock");
    endtask

    task automatic t_nop();
        for (int i = 0; i < 4; i++) begin
            ctl.cycle(1'b0, 1'b1, dsr_addr_t'(i), '0, 2'h0, 2'h0);
            chk_bit("q_oe nop", 1'b0, q_oe);
        end
        $display("done nop");
    endtask

    task automatic t_lanes();
        dsr_line_t w;
        for (int i = 0; i < 4; i++) begin
            wr(dsr_addr_t'(16 + i), 36'hfffffffff, 2'h0, 2'h0);
            wr(dsr_addr_t'(16 + i), 36'h13579bdf0 + i, 2'(i), 2'(3 - i));
        end
        idle(2);
        for (int i = 0; i < 4; i++) begin
            w = lane_exp(36'hfffffffff, 36'h13579bdf0 + i, 2'(i), 2'(3 - i));
            rd2(dsr_addr_t'(16 + i), '0, 1, w, w, 1'b1);
        end
        $display("done lanes");
    endtask

    task automatic t_b2b(input logic ddr2);
        wr(dsr_addr_t'(32), 36'h0a5a5c3c3, 2'h0, 2'h0);
        wr(dsr_addr_t'(33), 36'h95a5a3c3c, 2'h0, 2'h0);
        idle(1);
        // First read meets the second write still staged, the next one the array
        rd2(dsr_addr_t'(33), dsr_addr_t'(32), 2, 36'h95a5a3c3c, 36'h0a5a5c3c3, ddr2);
        $display("done b2b");
    endtask

    // Just after a K edge the lagging C has not moved yet
    task automatic t_echo(input logic st);
        @(posedge k_clk);
        #1;
        chk_bit("echo rise", st, echo);
        chk_bit("echo_n rise", ~st, echo_n);
        @(negedge k_clk);
        #1;
        chk_bit("echo fall", ~st, echo);
        $display("done echo");
    endtask

    task automatic t_zq();
        dsr_word_t n;
        n = '0;
        while (zq !== 1'b1) begin
            @(negedge clk_sys);
            n = n + 1'b1;
            if (n > 18'h00500) timeout();
        end
        n = '0;
        do begin
            @(negedge clk_sys);
            n = n + 1'b1;
            if (n == 18'h00001) chk_bit("zq width", 1'b0, zq);
            if (n > 18'h00500) timeout();
        end while (zq !== 1'b1);
        chk_word("zq period", 18'h00400, n);
        $display("done zq");
    endtask

    // Bounds the whole sequence so that a hang ends in the verdict
    initial begin
        repeat (5000) @(negedge clk_sys);
        timeout();
    end

    initial begin
        rst = 1'b1;
        pll_en = 1'b1;
        strap = 1'b0;
        k_run = 1'b1;
        failures = 0;
        num_checks = 0;
        do_reset(1'b1, 1'b0);
        t_lock();
        t_nop();
        t_lanes();
        t_b2b(1'b1);
        t_echo(1'b0);
        t_zq();
        do_reset(1'b0, 1'b0);
        t_b2b(1'b0);
        chk_bit("locked ddr1", 1'b0, locked);
        do_reset(1'b1, 1'b1);
        t_echo(1'b1);
        t_b2b(1'b1);
        wrap_up();
    end
endmodule
